// *** hdl/ldg_pkg.sv ***
// ldg_pkg: register map, field positions and reset values of the global configuration bank
package ldg_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;                                  // register address width
	localparam int DATA_W = 8;                                  // register data width
	localparam int NUM_MODULES = 8;                             // rgb modules with a grouping bit

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_DEVICE_ENABLE  = 8'h00;         // device_enable_config
	localparam logic [7:0] OFS_DEVICE_OPTIONS = 8'h01;         // device_options_config
	localparam logic [7:0] OFS_MODULE_GROUP   = 8'h02;         // module_grouping_config
	localparam logic [7:0] OFS_GROUP_INTENS   = 8'h03;         // group_intensity_level
	localparam logic [7:0] OFS_GROUP_COLOR_A  = 8'h04;         // group_color_a_level
	localparam logic [7:0] OFS_GROUP_COLOR_B  = 8'h05;         // group_color_b_level

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_DEVICE_ENABLE = 6;                       // global enable in enable register
	localparam int BIT_LOG_CURVE     = 5;                       // logarithmic dimming select
	localparam int BIT_POWER_SAVE    = 4;                       // automatic power saving
	localparam int BIT_AUTO_INCR     = 3;                       // address auto increment
	localparam int BIT_DITHER        = 2;                       // pwm dithering
	localparam int BIT_CURRENT_RANGE = 1;                       // output_current_range_select
	localparam int BIT_ALL_OFF       = 0;                       // all_outputs_off

	// writable masks: reserved bits never store
	localparam logic [7:0] MASK_DEVICE_ENABLE  = 8'h40;        // only bit 6 implemented
	localparam logic [7:0] MASK_DEVICE_OPTIONS = 8'h3F;        // bits 5..0 implemented

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_DEVICE_ENABLE  = 8'h00;         // device starts disabled
	localparam logic [7:0] RST_DEVICE_OPTIONS = 8'h3C;         // log, save, incr, dither set
	localparam logic [7:0] RST_MODULE_GROUP   = 8'h00;         // all modules independent
	localparam logic [7:0] RST_GROUP_INTENS   = 8'hFF;         // full brightness
	localparam logic [7:0] RST_GROUP_COLOR_A  = 8'h00;         // no colour a
	localparam logic [7:0] RST_GROUP_COLOR_B  = 8'h00;         // no colour b

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef logic [7:0] ldg_byte_t;                             // one register byte

	// decoded write/read selects, one per register
	typedef enum logic [2:0]
	{
		LDG_SEL_ENABLE  = 3'h0,
		LDG_SEL_OPTIONS = 3'h1,
		LDG_SEL_GROUP   = 3'h2,
		LDG_SEL_INTENS  = 3'h3,
		LDG_SEL_COLOR_A = 3'h4,
		LDG_SEL_COLOR_B = 3'h5,
		LDG_SEL_NONE    = 3'h7
	} ldg_sel_t;

	// address decode, used by both the write and the read path
	function automatic ldg_sel_t ldg_decode(input logic [7:0] addr);
		ldg_sel_t sel;
		sel = LDG_SEL_NONE;
		unique case (addr)
			OFS_DEVICE_ENABLE  : sel = LDG_SEL_ENABLE;
			OFS_DEVICE_OPTIONS : sel = LDG_SEL_OPTIONS;
			OFS_MODULE_GROUP   : sel = LDG_SEL_GROUP;
			OFS_GROUP_INTENS   : sel = LDG_SEL_INTENS;
			OFS_GROUP_COLOR_A  : sel = LDG_SEL_COLOR_A;
			OFS_GROUP_COLOR_B  : sel = LDG_SEL_COLOR_B;
			default            : sel = LDG_SEL_NONE;
		endcase
		return sel;
	endfunction

endpackage

// *** hdl/ldg_wr_if.sv ***
// ldg_wr_if: decoded write port carried from the bus front end to the register store
`timescale 1ns/10ps
interface ldg_wr_if;
	import ldg_pkg::*;

	logic      wr_en;                                           // one-cycle write pulse
	ldg_sel_t  wr_sel;                                          // decoded target register
	ldg_byte_t wr_data;                                         // byte to store

	// front end drives, register store receives
	modport source (output wr_en, output wr_sel, output wr_data);
	modport sink   (input wr_en, input wr_sel, input wr_data);
endinterface

// *** hdl/ldg_bus_front.sv ***
// ldg_bus_front: decodes host writes into the internal write interface
`timescale 1ns/10ps
module ldg_bus_front
	import ldg_pkg::*;
(
	// register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr,
	// decoded write
	ldg_wr_if.source               wr_port
);

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	// pass the strobe straight through; unmapped addresses decode to none
	always_comb
	begin
		wr_port.wr_en   = wr;
		wr_port.wr_sel  = ldg_decode(addr);
		wr_port.wr_data = wdata;
	end

endmodule // ldg_bus_front

// *** hdl/ldg_global_cfg.sv ***
// ldg_global_cfg: global configuration register bank of the led driver
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
module ldg_global_cfg
	import ldg_pkg::*;
(
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   rstn,
	// register port
	input  wire logic [ADDR_W-1:0]      addr,
	input  wire logic [DATA_W-1:0]      wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic      [DATA_W-1:0]      rdata,
	// device-wide controls
	output logic                        device_enable,
	output logic                        log_curve_select,
	output logic                        power_save_enable,
	output logic                        auto_increment_enable,
	output logic                        pwm_dither_enable,
	output logic                        output_current_range_select,
	output logic                        all_outputs_off,
	output logic                        outputs_active,
	// bank controls
	output logic      [NUM_MODULES-1:0] module_group_enable,
	output logic      [DATA_W-1:0]      group_intensity,
	output logic      [DATA_W-1:0]      group_color_a,
	output logic      [DATA_W-1:0]      group_color_b
);
	import ldg_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	ldg_wr_if  wr_port ();                                      // decoded write path
	ldg_byte_t enable_reg;                                      // device_enable_config store
	ldg_byte_t options_reg;                                     // device_options_config store
	ldg_byte_t group_reg;                                       // module_grouping_config store
	ldg_byte_t intens_reg;                                      // group_intensity_level store
	ldg_byte_t color_a_reg;                                     // group_color_a_level store
	ldg_byte_t color_b_reg;                                     // group_color_b_level store
	ldg_byte_t rdata_next;                                      // read mux result
	logic      outputs_active_next;                             // combined output gate

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	ldg_bus_front u_front
	(
		.addr    (addr),
		.wdata   (wdata),
		.wr      (wr),
		.wr_port (wr_port.source)
	);

	// ----------------------------------------------------------------
	// enable register
	// ----------------------------------------------------------------
	// only the global enable stores; reserved bits stay zero
	always_ff @(posedge clock)
	begin
		if (!rstn)
			enable_reg <= RST_DEVICE_ENABLE;
		else if (wr_port.wr_en && wr_port.wr_sel == LDG_SEL_ENABLE)
			enable_reg <= wr_port.wr_data & MASK_DEVICE_ENABLE;
	end

	// ----------------------------------------------------------------
	// options register
	// ----------------------------------------------------------------
	// bits 7..6 are masked so a write there changes nothing
	always_ff @(posedge clock)
	begin
		if (!rstn)
			options_reg <= RST_DEVICE_OPTIONS;
		else if (wr_port.wr_en && wr_port.wr_sel == LDG_SEL_OPTIONS)
			options_reg <= wr_port.wr_data & MASK_DEVICE_OPTIONS;
	end

	// ----------------------------------------------------------------
	// module grouping register
	// ----------------------------------------------------------------
	// one bit per module: set means shared bank control
	always_ff @(posedge clock)
	begin
		if (!rstn)
			group_reg <= RST_MODULE_GROUP;
		else if (wr_port.wr_en && wr_port.wr_sel == LDG_SEL_GROUP)
			group_reg <= wr_port.wr_data;
	end

	// ----------------------------------------------------------------
	// bank level registers
	// ----------------------------------------------------------------
	// brightness scales linearly, full at FFh
	always_ff @(posedge clock)
	begin
		if (!rstn)
			intens_reg <= RST_GROUP_INTENS;
		else if (wr_port.wr_en && wr_port.wr_sel == LDG_SEL_INTENS)
			intens_reg <= wr_port.wr_data;
	end

	// colour a mix percentage of banked modules
	always_ff @(posedge clock)
	begin
		if (!rstn)
			color_a_reg <= RST_GROUP_COLOR_A;
		else if (wr_port.wr_en && wr_port.wr_sel == LDG_SEL_COLOR_A)
			color_a_reg <= wr_port.wr_data;
	end

	// colour b mix percentage of banked modules
	always_ff @(posedge clock)
	begin
		if (!rstn)
			color_b_reg <= RST_GROUP_COLOR_B;
		else if (wr_port.wr_en && wr_port.wr_sel == LDG_SEL_COLOR_B)
			color_b_reg <= wr_port.wr_data;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// stored values already hold zero in reserved positions
	always_comb
	begin
		unique case (ldg_decode(addr))
			LDG_SEL_ENABLE  : rdata_next = enable_reg;
			LDG_SEL_OPTIONS : rdata_next = options_reg;
			LDG_SEL_GROUP   : rdata_next = group_reg;
			LDG_SEL_INTENS  : rdata_next = intens_reg;
			LDG_SEL_COLOR_A : rdata_next = color_a_reg;
			LDG_SEL_COLOR_B : rdata_next = color_b_reg;
			default         : rdata_next = 8'h00;               // unmapped reads zero
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (!rstn)
			rdata <= 8'h00;
		else if (rd)
			rdata <= rdata_next;
		else
			rdata <= 8'h00;
	end

	// ----------------------------------------------------------------
	// control outputs
	// ----------------------------------------------------------------
	// outputs run only when enabled and not globally shut down
	always_comb
	begin
		outputs_active_next = 1'b0;
		if (wr_port.wr_en && wr_port.wr_sel == LDG_SEL_OPTIONS)
			outputs_active_next = enable_reg[BIT_DEVICE_ENABLE] && !wr_port.wr_data[BIT_ALL_OFF];
		else if (wr_port.wr_en && wr_port.wr_sel == LDG_SEL_ENABLE)
			outputs_active_next = wr_port.wr_data[BIT_DEVICE_ENABLE] && !options_reg[BIT_ALL_OFF];
		else
			outputs_active_next = enable_reg[BIT_DEVICE_ENABLE] && !options_reg[BIT_ALL_OFF];
	end

	// registered copies of each field, one edge behind the stores; outputs_active updates on the store edge
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			device_enable               <= RST_DEVICE_ENABLE[BIT_DEVICE_ENABLE];
			log_curve_select            <= RST_DEVICE_OPTIONS[BIT_LOG_CURVE];
			power_save_enable           <= RST_DEVICE_OPTIONS[BIT_POWER_SAVE];
			auto_increment_enable       <= RST_DEVICE_OPTIONS[BIT_AUTO_INCR];
			pwm_dither_enable           <= RST_DEVICE_OPTIONS[BIT_DITHER];
			output_current_range_select <= RST_DEVICE_OPTIONS[BIT_CURRENT_RANGE];
			all_outputs_off             <= RST_DEVICE_OPTIONS[BIT_ALL_OFF];
			outputs_active              <= 1'b0;
			module_group_enable         <= RST_MODULE_GROUP;
			group_intensity             <= RST_GROUP_INTENS;
			group_color_a               <= RST_GROUP_COLOR_A;
			group_color_b               <= RST_GROUP_COLOR_B;
		end
		else
		begin
			device_enable               <= enable_reg[BIT_DEVICE_ENABLE];
			log_curve_select            <= options_reg[BIT_LOG_CURVE];
			power_save_enable           <= options_reg[BIT_POWER_SAVE];
			auto_increment_enable       <= options_reg[BIT_AUTO_INCR];
			pwm_dither_enable           <= options_reg[BIT_DITHER];
			output_current_range_select <= options_reg[BIT_CURRENT_RANGE];
			all_outputs_off             <= options_reg[BIT_ALL_OFF];
			outputs_active              <= outputs_active_next;
			module_group_enable         <= group_reg;
			group_intensity             <= intens_reg;
			group_color_a               <= color_a_reg;
			group_color_b               <= color_b_reg;
		end
	end

endmodule // ldg_global_cfg

// *** bench/ldg_global_cfg_checker.sv ***
// ldg_global_cfg_checker: concurrent checks on the ports of the global configuration bank
`timescale 1ns/10ps
module ldg_global_cfg_checker
	import ldg_pkg::*;
(
	// clock and reset
	input wire logic              clock,
	input wire logic              rstn,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic              wr,
	input wire logic              rd,
	input wire logic [DATA_W-1:0] rdata,
	// field outputs
	input wire logic              device_enable,
	input wire logic              log_curve_select,
	input wire logic              power_save_enable,
	input wire logic              auto_increment_enable,
	input wire logic              pwm_dither_enable,
	input wire logic              output_current_range_select,
	input wire logic              all_outputs_off,
	input wire logic              outputs_active,
	input wire logic [NUM_MODULES-1:0] module_group_enable,
	input wire logic [DATA_W-1:0] group_intensity,
	input wire logic [DATA_W-1:0] group_color_a
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	// one host write to the given offset
	sequence s_write(logic [7:0] ofs);
		wr && addr == ofs;
	endsequence
	// one host read of the given offset
	sequence s_read(logic [7:0] ofs);
		rd && addr == ofs;
	endsequence

	// ----------------------------------------------------------------
	// stores reach the field outputs two edges after the write
	// ----------------------------------------------------------------
	a_enable_store: assert property (s_write(OFS_DEVICE_ENABLE) |-> ##2 device_enable == $past(wdata[6], 2))
		else $error("enable output does not follow its write");
	a_options_store: assert property (s_write(OFS_DEVICE_OPTIONS) |-> ##2 {log_curve_select, power_save_enable, auto_increment_enable, pwm_dither_enable, output_current_range_select, all_outputs_off} == $past(wdata[5:0], 2))
		else $error("option outputs do not follow their write");
	a_group_store: assert property (s_write(OFS_MODULE_GROUP) |-> ##2 module_group_enable == $past(wdata, 2))
		else $error("grouping output does not follow its write");
	a_intensity_store: assert property (s_write(OFS_GROUP_INTENS) |-> ##2 group_intensity == $past(wdata, 2))
		else $error("intensity output does not follow its write");
	a_color_a_store: assert property (s_write(OFS_GROUP_COLOR_A) |-> ##2 group_color_a == $past(wdata, 2))
		else $error("colour a output does not follow its write");

	// ----------------------------------------------------------------
	// global off, reserved bits and idle read data
	// ----------------------------------------------------------------
	a_global_off: assert property (s_write(OFS_DEVICE_OPTIONS) ##0 wdata[0] |=> !outputs_active)
		else $error("outputs stay active after global off");
	a_enable_rsvd_zero: assert property (s_read(OFS_DEVICE_ENABLE) |=> (rdata & 8'hBF) == 8'h00)
		else $error("reserved enable bits read non zero");
	a_options_rsvd_zero: assert property (s_read(OFS_DEVICE_OPTIONS) |=> rdata[7:6] == 2'b00)
		else $error("reserved option bits read non zero");
	a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
endmodule // ldg_global_cfg_checker

// *** bench/ldg_global_cfg_test.sv ***
// ldg_global_cfg_test: self-checking bench for the global configuration bank
`timescale 1ns/10ps
module ldg_global_cfg_test;
	import ldg_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic       clock, rstn, wr, rd;                // clock, reset, strobes
	logic [7:0] addr, wdata, rdata;                 // register port
	logic [7:0] grp, inten, col_a, col_b;           // bank outputs
	logic       en, lg, ps, ai, di, rg, off, act;   // device-wide outputs
	logic [7:0] mdl [0:5];                          // register model after each store
	logic [7:0] fld [0:5];                          // what the field outputs should show
	logic [7:0] exp_rd;                             // expected read data
	logic [7:0] rst_v [0:5] = '{RST_DEVICE_ENABLE, RST_DEVICE_OPTIONS, RST_MODULE_GROUP,
		RST_GROUP_INTENS, RST_GROUP_COLOR_A, RST_GROUP_COLOR_B};
	logic [7:0] msk [0:5] = '{MASK_DEVICE_ENABLE, MASK_DEVICE_OPTIONS, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	logic [31:0] r;                                 // random draw
	int         fail_count, n_compared, seed;       // counters and seed
	bit         live;                               // model in step with design

	ldg_global_cfg ldg_global_cfg_i (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .device_enable(en), .log_curve_select(lg), .power_save_enable(ps),
		.auto_increment_enable(ai), .pwm_dither_enable(di), .output_current_range_select(rg),
		.all_outputs_off(off), .outputs_active(act), .module_group_enable(grp),
		.group_intensity(inten), .group_color_a(col_a), .group_color_b(col_b));

	// free-running clock, 25 ns period
	always #12.5 clock = ~clock;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	// compare one byte result
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one bus access, called just after a rising edge
	task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
		wr <= w;
		rd <= ~w;
		addr <= a;
		wdata <= d;
		@(posedge clock);
	endtask
	// strobes low for n cycles
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clock);
	endtask
	// counts and verdict
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// model: stores at the strobe edge, fields one edge later
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		exp_rd = 8'h00;
		if (!rstn)
		begin
			mdl = rst_v;
			fld = rst_v;
			live = 1'b1;
		end
		else
		begin
			fld = mdl;
			// unmapped places read zero and ignore writes
			if (rd && addr < 8'h06)
				exp_rd = mdl[addr[2:0]];
			if (wr && addr < 8'h06)
				mdl[addr[2:0]] = wdata & msk[addr[2:0]];
		end
	end

	// every result checked mid-cycle, where it is settled
	always @(negedge clock)
		if (live)
		begin
			cmp(rdata, exp_rd);
			cmp({1'b0, en, 6'h00}, fld[0]);
			cmp({2'b00, lg, ps, ai, di, rg, off}, fld[1]);
			cmp(grp, fld[2]);
			cmp(inten, fld[3]);
			cmp(col_a, fld[4]);
			cmp(col_b, fld[5]);
			cmp({7'h00, act}, {7'h00, mdl[0][6] & ~mdl[1][0]});
		end

	// hang guard
	initial
	begin
		repeat (100000) @(posedge clock);
		fail_count++;
		finish_test;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		seed = 49;
		repeat (2)
		begin
			repeat (5) @(posedge clock);
			rstn <= 1'b1;
			// reset values, then one unmapped place
			for (int a = 0; a < 7; a++)
				op(1'b0, a[7:0], 8'h00);
			// reserved bits written high, read back at once
			op(1'b1, OFS_DEVICE_ENABLE, 8'hFF);
			op(1'b0, OFS_DEVICE_ENABLE, 8'h00);
			op(1'b1, OFS_DEVICE_OPTIONS, 8'hFF);
			op(1'b0, OFS_DEVICE_OPTIONS, 8'h00);
			op(1'b1, OFS_DEVICE_OPTIONS, 8'h00);
			op(1'b1, 8'h06, 8'hA5);
			idle(3);
			// random traffic, back to back or with gaps
			repeat (300)
			begin
				r = $random(seed);
				op(r[0], {4'h0, r[11:8]}, r[23:16]);
				if (r[31])
					idle(1);
			end
			idle(2);
			rstn <= 1'b0;
		end
		finish_test;
	end
endmodule // ldg_global_cfg_test

bind ldg_global_cfg ldg_global_cfg_checker ldg_global_cfg_checker_i (.clock(clock), .rstn(rstn),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .device_enable(device_enable),
	.log_curve_select(log_curve_select), .power_save_enable(power_save_enable),
	.auto_increment_enable(auto_increment_enable), .pwm_dither_enable(pwm_dither_enable),
	.output_current_range_select(output_current_range_select), .all_outputs_off(all_outputs_off),
	.outputs_active(outputs_active), .module_group_enable(module_group_enable),
	.group_intensity(group_intensity), .group_color_a(group_color_a));
